// ---- pkg/txtb_map.svh ----
// constants of the transmit telecom bus framer: frame geometry, overhead bytes, clock rates
// assumes inclusion by txtb_pkg, txtb_top, the monitor and the bench, by bare name
`ifndef TXTB_MAP_SVH
`define TXTB_MAP_SVH

`define TXTB_MCLK_KHZ      100000
`define TXTB_BUS_CLK_KHZ   19440
`define TXTB_NCO_W         24

`define TXTB_LAST_ROW      4'h8
`define TXTB_LAST_COL      9'h10D
`define TXTB_TOH_COLS      9'h009
`define TXTB_C1_ROW        4'h0
`define TXTB_C1_COL        9'h006
`define TXTB_PTR_ROW       4'h3
`define TXTB_J1_COL        9'h009
`define TXTB_J1_LAST_COL   9'h00B
`define TXTB_A2_COL        9'h003
`define TXTB_H3_COL        9'h006

`define TXTB_A1_BYTE       8'hF6
`define TXTB_A2_BYTE       8'h28
`define TXTB_J0_BYTE       8'h01
`define TXTB_H1_BYTE       8'h60
`define TXTB_H2_BYTE       8'h00
`define TXTB_H1_CAT_BYTE   8'h93
`define TXTB_H2_CAT_BYTE   8'hFF
`define TXTB_FILL_BYTE     8'h00

`define TXTB_FIFO_W        8
`define TXTB_FIFO_DEPTH    16

`endif

// ---- pkg/txtb_pkg.sv ----
// types shared by the transmit telecom bus framer modules
// assumes txtb_map.svh on the include path
`include "txtb_map.svh"

package txtb_pkg;

  typedef enum logic [1:0] {
    TXTB_KIND_TOH = 2'b00,
    TXTB_KIND_C1  = 2'b01,
    TXTB_KIND_J1  = 2'b10,
    TXTB_KIND_PAY = 2'b11
  } txtb_kind_t;

  typedef struct packed {
    logic                   en_s1;
    logic                   en_s2;
    logic                   mode_s1;
    logic                   mode_s2;
    logic                   cat_s1;
    logic                   cat_s2;
    logic [`TXTB_NCO_W-1:0] acc;
    logic                   clk_out;
    logic [3:0]             row;
    logic [8:0]             col;
    logic [7:0]             bus_byte;
    logic                   pl;
    logic                   marker;
  } txtb_top_st_t;

endpackage

// ---- verilog/txtb_fifo.sv ----
// byte fifo between the user payload source and the bus framer
// assumes one clock and a reset already synchronised to it
`timescale 1ns/100ps
`default_nettype none

module txtb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         wr_valid,
  output logic              wr_ready,
  output logic [W-1:0]      rd_data,
  output logic              rd_valid,
  input  wire logic         rd_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
  } txtb_fifo_st_t;

  localparam logic [AW:0]   FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  txtb_fifo_st_t cur_ff;
  txtb_fifo_st_t nxt_st;
  logic          do_wr;
  logic          do_rd;

  assign wr_ready = (cur_ff.count != FULL_CNT);
  assign rd_valid = (cur_ff.count != '0);
  assign rd_data  = cur_ff.mem[cur_ff.rd_ptr];
  assign do_wr    = wr_valid && wr_ready;
  assign do_rd    = rd_ready && rd_valid;

  always_comb begin
    nxt_st = cur_ff;
    if (do_wr) begin
      nxt_st.mem[cur_ff.wr_ptr] = wr_data;
      nxt_st.wr_ptr = (cur_ff.wr_ptr == LAST_PTR) ? '0 : cur_ff.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      nxt_st.rd_ptr = (cur_ff.rd_ptr == LAST_PTR) ? '0 : cur_ff.rd_ptr + 1'b1;
    end
    if (do_wr && !do_rd) begin
      nxt_st.count = cur_ff.count + 1'b1;
    end else if (do_rd && !do_wr) begin
      nxt_st.count = cur_ff.count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

endmodule // txtb_fifo

`default_nettype wire

// ---- verilog/txtb_top.sv ----
// transmit telecom bus framer: builds STS-3/STM-1 frames from a payload byte stream
// assumes mclk at 100 MHz; enable and mode inputs may come from pins
`timescale 1ns/100ps
`default_nettype none
`include "txtb_map.svh"

module txtb_top
  import txtb_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       bus_enable,
  input  wire logic       rephase_off_mode,
  input  wire logic       sts3c_mode,
  input  wire logic [7:0] in_byte,
  input  wire logic       in_valid,
  output logic            in_ready,
  output logic            tx_bus_clock_out,
  output logic [7:0]      tx_bus_byte,
  output logic            payload_indicator,
  output logic            frame_phase_marker
);

  ////////////////////////////////////////////////////////////////////////////
  // constants

  localparam int NW = `TXTB_NCO_W;
  // fractional step: 19.44 MHz is no integer divide of 100 MHz
  localparam logic [NW-1:0] NCO_INC =
    NW'((64'(`TXTB_BUS_CLK_KHZ) << NW) / 64'(`TXTB_MCLK_KHZ));

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // payload buffer

  logic [7:0] pay_byte;
  logic       pay_valid;
  logic       pay_ready;

  txtb_fifo #(
    .W     (`TXTB_FIFO_W),
    .DEPTH (`TXTB_FIFO_DEPTH)
  ) u_fifo (
    .clk      (mclk),
    .rst_n    (rst_n),
    .wr_data  (in_byte),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .rd_data  (pay_byte),
    .rd_valid (pay_valid),
    .rd_ready (pay_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame position helpers

  function automatic txtb_kind_t slot_kind(
    input logic [3:0] row,
    input logic [8:0] col,
    input logic       cat
  );
    txtb_kind_t k;
    k = TXTB_KIND_PAY;
    if (col < `TXTB_TOH_COLS) begin
      k = TXTB_KIND_TOH;
      if (row == `TXTB_C1_ROW && col == `TXTB_C1_COL) begin
        k = TXTB_KIND_C1;
      end
    // pointer held at zero offset, so J1 follows H3 in the pointer row
    end else if (row == `TXTB_PTR_ROW && col == `TXTB_J1_COL) begin
      k = TXTB_KIND_J1;
    end else if (row == `TXTB_PTR_ROW && !cat && col <= `TXTB_J1_LAST_COL) begin
      k = TXTB_KIND_J1;
    end
    return k;
  endfunction

  function automatic logic [7:0] toh_byte(
    input logic [3:0] row,
    input logic [8:0] col,
    input logic       cat
  );
    logic [7:0] b;
    logic       slave;
    b = `TXTB_FILL_BYTE;
    // in concatenated mode only the first pointer carries a value
    slave = cat && col != 9'h000 && col != `TXTB_A2_COL;
    if (row == `TXTB_C1_ROW) begin
      if (col < `TXTB_A2_COL) begin
        b = `TXTB_A1_BYTE;
      end else if (col < `TXTB_C1_COL) begin
        b = `TXTB_A2_BYTE;
      end else if (col == `TXTB_C1_COL) begin
        b = `TXTB_J0_BYTE;
      end
    end else if (row == `TXTB_PTR_ROW) begin
      if (col < `TXTB_A2_COL) begin
        b = slave ? `TXTB_H1_CAT_BYTE : `TXTB_H1_BYTE;
      end else if (col < `TXTB_H3_COL) begin
        b = slave ? `TXTB_H2_CAT_BYTE : `TXTB_H2_BYTE;
      end
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  txtb_top_st_t      cur_ff;
  txtb_top_st_t      nxt_st;
  logic [NW:0]       acc_sum;
  logic              tick;
  logic              en;
  txtb_kind_t        kind;
  logic              pay_slot;

  assign en       = cur_ff.en_s2;
  assign kind     = slot_kind(cur_ff.row, cur_ff.col, cur_ff.cat_s2);
  assign pay_slot = (kind == TXTB_KIND_PAY) || (kind == TXTB_KIND_J1);
  assign acc_sum  = {1'b0, cur_ff.acc} + {1'b0, NCO_INC};
  // bus clock rising edge: msb of the phase goes from low to high
  assign tick     = !cur_ff.acc[NW-1] && acc_sum[NW-1];
  // payload drains only on payload slots of a bus period
  assign pay_ready = tick && en && pay_slot;

  always_comb begin
    nxt_st         = cur_ff;
    nxt_st.en_s1   = bus_enable;
    nxt_st.en_s2   = cur_ff.en_s1;
    nxt_st.mode_s1 = rephase_off_mode;
    nxt_st.mode_s2 = cur_ff.mode_s1;
    nxt_st.cat_s1  = sts3c_mode;
    nxt_st.cat_s2  = cur_ff.cat_s1;
    nxt_st.acc     = acc_sum[NW-1:0];
    nxt_st.clk_out = acc_sum[NW-1];
    if (tick) begin
      if (!en) begin
        nxt_st.row      = 4'h0;
        nxt_st.col      = 9'h000;
        nxt_st.bus_byte = `TXTB_FILL_BYTE;
        nxt_st.pl       = 1'b0;
        nxt_st.marker   = 1'b0;
      end else begin
        // an empty buffer sends fill rather than stalling the frame
        if (pay_slot) begin
          nxt_st.bus_byte = pay_valid ? pay_byte : `TXTB_FILL_BYTE;
        end else begin
          nxt_st.bus_byte = toh_byte(cur_ff.row, cur_ff.col, cur_ff.cat_s2);
        end
        nxt_st.pl = pay_slot;
        // marker only on C1/J0 and J1 slots, gated by mode
        nxt_st.marker = cur_ff.mode_s2 &&
                        (kind == TXTB_KIND_C1 || kind == TXTB_KIND_J1);
        if (cur_ff.col == `TXTB_LAST_COL) begin
          nxt_st.col = 9'h000;
          nxt_st.row = (cur_ff.row == `TXTB_LAST_ROW) ? 4'h0 : cur_ff.row + 4'h1;
        end else begin
          nxt_st.col = cur_ff.col + 9'h001;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign tx_bus_clock_out   = cur_ff.clk_out;
  assign tx_bus_byte        = cur_ff.bus_byte;
  assign payload_indicator  = cur_ff.pl;
  // marker updated only at a tick: one bus period, three for J1 outside concatenated mode
  assign frame_phase_marker = cur_ff.marker;

endmodule // txtb_top

`default_nettype wire

// ---- verif/txtb_top_monitor.sv ----
// assertions on the telecom bus outputs of txtb_top
// assumes a bind into txtb_top; all checks on mclk
`timescale 1ns/100ps
`default_nettype none
`include "txtb_map.svh"
module txtb_top_monitor (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       bus_enable,
  input wire logic       rephase_off_mode,
  input wire logic       tx_bus_clock_out,
  input wire logic [7:0] tx_bus_byte,
  input wire logic       payload_indicator,
  input wire logic       frame_phase_marker
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_tick;
    $rose(tx_bus_clock_out);
  endsequence
  sequence s_gap;
    (!$rose(tx_bus_clock_out)) [*4];
  endsequence
  property p_period;
    s_tick |=> s_gap ##[1:2] s_tick;
  endproperty
  a_period: assert property (p_period) else $error("bus period off");
  property p_byte_edge;
    $changed(tx_bus_byte) |-> s_tick;
  endproperty
  a_byte_edge: assert property (p_byte_edge) else $error("byte off edge");
  property p_pl_edge;
    $changed(payload_indicator) |-> s_tick;
  endproperty
  a_pl_edge: assert property (p_pl_edge) else $error("pl off edge");
  property p_mk_edge;
    $changed(frame_phase_marker) |-> s_tick;
  endproperty
  a_mk_edge: assert property (p_mk_edge) else $error("marker off edge");
  property p_c1_byte;
    frame_phase_marker && !payload_indicator |-> tx_bus_byte == `TXTB_J0_BYTE;
  endproperty
  a_c1_byte: assert property (p_c1_byte) else $error("marker on wrong toh");
  // no tick fits in the first four cycles of a period
  property p_c1_width;
    $rose(frame_phase_marker) && !payload_indicator |=>
      frame_phase_marker [*4] ##[1:2] !frame_phase_marker;
  endproperty
  a_c1_width: assert property (p_c1_width) else $error("c1 pulse width");
  property p_j1_start;
    $rose(frame_phase_marker) && payload_indicator |-> !$past(payload_indicator);
  endproperty
  a_j1_start: assert property (p_j1_start) else $error("marker inside spe");
  property p_no_phase;
    (!rephase_off_mode || !bus_enable) [*8] ##1 (!rephase_off_mode || !bus_enable) [*4]
      |-> !frame_phase_marker;
  endproperty
  a_no_phase: assert property (p_no_phase) else $error("marker while gated");
endmodule // txtb_top_monitor
bind txtb_top txtb_top_monitor i_mon (
  .mclk(mclk), .arst_n(arst_n), .bus_enable(bus_enable),
  .rephase_off_mode(rephase_off_mode), .tx_bus_clock_out(tx_bus_clock_out),
  .tx_bus_byte(tx_bus_byte), .payload_indicator(payload_indicator),
  .frame_phase_marker(frame_phase_marker)
);
`default_nettype wire

// ---- verif/txtb_fr_model.sv ----
// downstream framer model: samples the telecom bus once per bus period
// assumes the bus clock is forwarded with the outputs
`timescale 1ns/100ps
`default_nettype none
module txtb_fr_model (
  input  wire logic       bus_clk,
  input  wire logic [7:0] bus_byte,
  input  wire logic       pl,
  input  wire logic       mk,
  output logic [7:0]      seen_byte,
  output logic            seen_pl,
  output logic            seen_mk,
  output int              n_seen
);
  int cnt = 0;
  assign n_seen = cnt;
  // falling edge keeps clear of the launching rise
  always @(negedge bus_clk) begin
    seen_byte <= bus_byte;
    seen_pl   <= pl;
    seen_mk   <= mk;
    cnt       <= cnt + 1;
  end
endmodule // txtb_fr_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// bench for txtb_top: fills the fifo, then checks whole frames in three modes
// assumes txtb_fr_model as the far side
`timescale 1ns/100ps
`default_nettype none
`include "txtb_map.svh"
module tb_top;
  logic       mclk             = 1'b0;
  logic       arst_n           = 1'b0;
  logic       bus_enable       = 1'b0;
  logic       rephase_off_mode = 1'b0;
  logic       sts3c_mode       = 1'b0;
  logic [7:0] in_byte          = 8'h00;
  logic       in_valid         = 1'b0;
  logic       in_ready;
  logic       bus_clk;
  logic [7:0] bus_byte;
  logic       pl;
  logic       mk;
  logic [7:0] s_byte;
  logic       s_pl;
  logic       s_mk;
  int         n_seen;
  int         error_cnt        = 0;
  int         n_checks         = 0;
  logic [7:0] pay_q[$];
  always #5 mclk = ~mclk;
  txtb_top i_dut (
    .mclk(mclk), .arst_n(arst_n), .bus_enable(bus_enable),
    .rephase_off_mode(rephase_off_mode), .sts3c_mode(sts3c_mode), .in_byte(in_byte),
    .in_valid(in_valid), .in_ready(in_ready), .tx_bus_clock_out(bus_clk),
    .tx_bus_byte(bus_byte), .payload_indicator(pl), .frame_phase_marker(mk)
  );
  txtb_fr_model i_far (
    .bus_clk(bus_clk), .bus_byte(bus_byte), .pl(pl), .mk(mk),
    .seen_byte(s_byte), .seen_pl(s_pl), .seen_mk(s_mk), .n_seen(n_seen)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // reads the samples half a system clock later, clear of the model's update
  task automatic wait_smp;
    int n;
    n = n_seen;
    wait (n_seen != n);
    @(negedge mclk);
  endtask
  // bus is disabled first, so nothing drains and the fifo must refuse
  task automatic t_fill;
    int i;
    @(posedge mclk);
    bus_enable <= 1'b0;
    repeat (20) @(posedge mclk);
    in_valid <= 1'b1;
    in_byte  <= 8'h3C;
    for (i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (in_ready !== 1'b1)
        break;
      pay_q.push_back(in_byte);
      @(posedge mclk);
      in_byte <= in_byte + 8'h1D;
    end
    repeat (3) @(posedge mclk);
    chk("full ready", 16'h0000, in_ready);
    chk("fill count", 16'h0010, 16'(i));
    in_valid <= 1'b0;
  endtask
  // consumes the payload queue; underrun slots carry the fill byte
  function automatic logic [9:0] exp_at(int r, int c, logic cat, logic mk_on);
    logic [7:0] b;
    logic       m;
    b = 8'h00;
    if (r == 0 && c < 3)
      b = `TXTB_A1_BYTE;
    else if (r == 0 && c < 6)
      b = `TXTB_A2_BYTE;
    else if (r == 0 && c == 6)
      b = `TXTB_J0_BYTE;
    else if (r == 3 && c < 3)
      b = (cat && c > 0) ? `TXTB_H1_CAT_BYTE : `TXTB_H1_BYTE;
    else if (r == 3 && c < 6)
      b = (cat && c > 3) ? `TXTB_H2_CAT_BYTE : `TXTB_H2_BYTE;
    else if (c >= 9)
      b = (pay_q.size() > 0) ? pay_q.pop_front() : `TXTB_FILL_BYTE;
    m = (r == 0 && c == 6) || (r == 3 && (c == 9 || (!cat && c > 9 && c < 12)));
    return {b, c >= 9, mk_on && m};
  endfunction
  task automatic t_frame(logic cat, logic mk_on);
    logic [9:0] e;
    realtime    t0;
    @(posedge mclk);
    bus_enable       <= 1'b0;
    sts3c_mode       <= cat;
    rephase_off_mode <= mk_on;
    repeat (20) @(posedge mclk);
    chk("idle bus", 16'h0000, {bus_byte, pl, mk});
    bus_enable <= 1'b1;
    do wait_smp; while (s_byte === 8'h00);
    t0 = $realtime;
    for (int r = 0; r < 9; r++) begin
      for (int c = 0; c < 270; c++) begin
        if (r + c > 0)
          wait_smp;
        e = exp_at(r, c, cat, mk_on);
        chk("byte", e[9:2], s_byte);
        chk("pl", e[1], s_pl);
        chk("marker", e[0], s_mk);
      end
    end
    wait_smp;
    chk("frame ns", 16'h0001, $realtime - t0 > 124970.0 && $realtime - t0 < 125030.0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    t_fill;
    t_frame(1'b0, 1'b1);
    t_fill;
    t_frame(1'b1, 1'b1);
    t_frame(1'b0, 1'b0);
    final_report;
  end
  initial begin
    // three frames of 12500 cycles, fills and margin
    repeat (50000) @(posedge mclk);
    error_cnt++;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
